// ### design/dacr_pkg.sv
// constants, field layout and carrier types of the converter control block
package dacr_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_PRIMARY = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_SECONDARY = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CONTROL = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLEAR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_SYNC_STATUS = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_CONVERSION_VALUE = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_BUFFERED_VALUE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_END = 5'h10;
  localparam int CA_SOFT_RESET = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_STANDBY_RUN = 2;
  localparam int CB_PIN_DRIVE = 0;
  localparam int CB_INTERNAL_ROUTE = 1;
  localparam int CB_JUSTIFY_HIGH = 2;
  localparam int CB_PUMP_DISABLE = 3;
  localparam int CB_REF_LSB = 6;
  localparam int EV_START_IN = 0;
  localparam int EV_EMPTY_OUT = 1;
  localparam int EV_EDGE_INVERT = 4;
  localparam int IRQ_UNDERRUN = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_SYNC_DONE = 2;
  localparam int ST_SYNC_BUSY = 7;
  localparam logic [7:0] CONTROL_SECONDARY_RST = 8'h00;
  localparam logic [7:0] EVENT_CONTROL_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  // reference_select encodings
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXTERNAL_PIN = 2'h2;
  // synchronising operations
  localparam int OP_SOFT_RESET = 0;
  localparam int OP_ENABLE = 1;
  localparam int OP_CONVERSION = 2;
  localparam int OP_BUFFERED = 3;
  localparam int NUM_OPS = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYNC_TIME_NS = 32;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic sel;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } dacr_bus_req_t;
  typedef struct packed {
    logic [1:0] ref_sel;
    logic pin_drive;
    logic adc_mux_drive;
    logic comparator_route;
    logic pump_force_off;
    logic output_buffer_on;
  } dacr_analog_t;
endpackage

// ### design/dacr_ctrl.sv
// converter control: registers, sync handshake, two-stage value buffer
`timescale 1ns/1ps
module dacr_ctrl #(
  parameter int SYNC_CYC = dacr_pkg::SYNC_CYCLES,
  parameter int CODE_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire dacr_pkg::dacr_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_ready,
  output logic bus_err,
  input wire logic start_event,
  input wire logic standby,
  output logic empty_event,
  output logic irq,
  output logic core_enable,
  output dacr_pkg::dacr_analog_t analog,
  output logic [CODE_W-1:0] code_data,
  output logic code_valid,
  input wire logic code_ready
);
  import dacr_pkg::*;

  localparam int CNT_W = $clog2(SYNC_CYC + 1);
  localparam int A_SYNC_MAX = 40;

  // ****************************************
  // state
  // ****************************************
  logic soft_reset_bit_reg, enable_reg, enable_active_reg, standby_run_reg;
  logic [7:0] ctrl_sec_reg, ev_ctrl_reg;
  logic [2:0] inten_reg, flags_reg, flags_next;
  logic [15:0] conv_pend_reg, buf_pend_reg, buf_reg;
  logic buf_full_reg, start_pend_reg;
  logic [CNT_W-1:0] cnt_reg [NUM_OPS];
  logic [NUM_OPS-1:0] op_start, op_done, op_busy, op_room;
  logic soft_clr, clr_all;
  logic ev_s1_reg, ev_s2_reg, ev_s3_reg, ev_lvl_reg, ev_edge;
  logic [CODE_W-1:0] fifo_mem [2];
  logic fifo_wp_reg, fifo_rp_reg;
  logic [1:0] fifo_cnt_reg;
  logic fifo_room, push, pop, start_take, transfer;
  logic [15:0] push_value;
  logic [CODE_W-1:0] push_code;

  // ****************************************
  // bus decode
  // ****************************************
  logic wr, mapped, word0, word1, word2, word3, reset_busy;
  logic soft_reset_bit_wr, others_ok, locked, err_now;
  logic wr_control_primary, wr_control_secondary, wr_event_control, wr_inten_clr, wr_inten_set, wr_flags;
  logic wr_conv, wr_buf;
  logic [7:0] wb0, wb1, wb2;
  logic [31:0] rd_word;

  // access classification by word and byte lane; all lanes decoded at once
  assign wr = bus_req.sel & bus_req.write;
  assign mapped = bus_req.addr < OFS_END;
  assign word0 = bus_req.addr[4:2] == OFS_CONTROL_PRIMARY[4:2];
  assign word1 = bus_req.addr[4:2] == OFS_IRQ_ENABLE_CLEAR[4:2];
  assign word2 = bus_req.addr[4:2] == OFS_CONVERSION_VALUE[4:2];
  assign word3 = bus_req.addr[4:2] == OFS_BUFFERED_VALUE[4:2];
  assign wb0 = bus_req.wdata[7:0];
  assign wb1 = bus_req.wdata[15:8];
  assign wb2 = bus_req.wdata[23:16];
  assign reset_busy = op_busy[OP_SOFT_RESET];
  assign locked = enable_reg | enable_active_reg;
  assign wr_control_primary = wr & word0 & bus_req.be[0];
  assign soft_reset_bit_wr = wr_control_primary & wb0[CA_SOFT_RESET] & ~reset_busy;
  assign others_ok = ~reset_busy & ~soft_reset_bit_wr;
  assign wr_control_secondary = wr & word0 & bus_req.be[1] & others_ok & ~locked;
  assign wr_event_control = wr & word0 & bus_req.be[2] & others_ok & ~locked;
  assign wr_inten_clr = wr & word1 & bus_req.be[0] & others_ok;
  assign wr_inten_set = wr & word1 & bus_req.be[1] & others_ok;
  assign wr_flags = wr & word1 & bus_req.be[2] & others_ok;
  assign wr_conv = wr & word2 & (|bus_req.be[1:0]) & others_ok;
  assign wr_buf = wr & word3 & (|bus_req.be[1:0]) & others_ok;

  // operations start only when their own busy is low, else they are dropped
  always_comb begin
    op_start = '0;
    op_start[OP_SOFT_RESET] = soft_reset_bit_wr;
    op_start[OP_ENABLE] = wr_control_primary & others_ok & ~op_busy[OP_ENABLE];
    op_start[OP_CONVERSION] = wr_conv & ~op_busy[OP_CONVERSION];
    op_start[OP_BUFFERED] = wr_buf & ~op_busy[OP_BUFFERED];
  end

  // error on an unmapped address or on a collision with a running sync
  always_comb begin
    err_now = bus_req.sel & ~mapped;
    if (wr_control_primary & wb0[CA_SOFT_RESET] & reset_busy) begin
      err_now = 1'b1;
    end
    if (wr_control_primary & others_ok & op_busy[OP_ENABLE]) begin
      err_now = 1'b1;
    end
    if (wr_conv & op_busy[OP_CONVERSION]) begin
      err_now = 1'b1;
    end
    if (wr_buf & op_busy[OP_BUFFERED]) begin
      err_now = 1'b1;
    end
  end

  // read data by word; reserved bytes and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (bus_req.addr[4:2])
      3'h0: begin
        rd_word = {8'h00, ev_ctrl_reg, ctrl_sec_reg,
                   5'h00, standby_run_reg, enable_reg, soft_reset_bit_reg};
      end
      3'h1: begin
        rd_word = {(|op_busy), 7'h00, 5'h00, flags_reg, 5'h00, inten_reg, 5'h00, inten_reg};
      end
      3'h2: begin
        rd_word = {16'h0000, conv_pend_reg};
      end
      3'h3: begin
        rd_word = {16'h0000, buf_pend_reg};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // every request is answered on the next edge
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ready <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_ready <= bus_req.sel;
      bus_err <= err_now;
      bus_rdata <= (bus_req.sel & ~bus_req.write) ? rd_word : 32'h0000_0000;
    end
  end

  // ****************************************
  // synchronisation counters
  // ****************************************
  assign soft_clr = op_done[OP_SOFT_RESET];
  assign clr_all = rst | soft_clr;
  always_comb begin
    op_room = '1;
    op_room[OP_CONVERSION] = fifo_room;
  end

  // one down-counter per operation; a conversion waits for buffer room
  for (genvar i = 0; i < NUM_OPS; i++) begin : g_sync
    assign op_busy[i] = cnt_reg[i] != '0;
    assign op_done[i] = (cnt_reg[i] == CNT_W'(1)) & op_room[i];
    always_ff @(posedge clk) begin
      if (clr_all) begin
        cnt_reg[i] <= '0;
      end else if (op_start[i]) begin
        cnt_reg[i] <= CNT_W'(SYNC_CYC);
      end else if (op_busy[i] & ~((cnt_reg[i] == CNT_W'(1)) & ~op_room[i])) begin
        cnt_reg[i] <= cnt_reg[i] - CNT_W'(1);
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // primary control; soft reset reads one until its sync completes
  always_ff @(posedge clk) begin
    if (clr_all) begin
      soft_reset_bit_reg <= 1'b0;
      enable_reg <= 1'b0;
      enable_active_reg <= 1'b0;
      standby_run_reg <= 1'b0;
    end else begin
      if (soft_reset_bit_wr) begin
        soft_reset_bit_reg <= 1'b1;
      end
      if (op_start[OP_ENABLE]) begin
        enable_reg <= wb0[CA_ENABLE];
      end
      if (wr_control_primary & others_ok) begin
        standby_run_reg <= wb0[CA_STANDBY_RUN];
      end
      if (op_done[OP_ENABLE]) begin
        enable_active_reg <= enable_reg;
      end
    end
  end

  // enable-protected secondary control and event control
  always_ff @(posedge clk) begin
    if (clr_all) begin
      ctrl_sec_reg <= CONTROL_SECONDARY_RST;
      ev_ctrl_reg <= EVENT_CONTROL_RST;
    end else begin
      if (wr_control_secondary) begin
        ctrl_sec_reg <= wb1 & 8'hCF;
      end
      if (wr_event_control) begin
        ev_ctrl_reg <= wb2 & 8'h13;
      end
    end
  end

  // interrupt enables: clear byte and set byte share one register
  always_ff @(posedge clk) begin
    if (clr_all) begin
      inten_reg <= IRQ_RST;
    end else begin
      inten_reg <= (inten_reg & ~(wr_inten_clr ? wb0[2:0] : 3'h0))
                   | (wr_inten_set ? wb1[2:0] : 3'h0);
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = flags_next & ~wb2[2:0];
    end
    if (wr_buf) begin
      flags_next[IRQ_EMPTY] = 1'b0;
    end
    if (start_take & ~buf_full_reg) begin
      flags_next[IRQ_UNDERRUN] = 1'b1;
    end
    if (transfer) begin
      flags_next[IRQ_EMPTY] = 1'b1;
    end
    if (|op_done[NUM_OPS-1:1]) begin
      flags_next[IRQ_SYNC_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr_all) begin
      flags_reg <= IRQ_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign irq = |(flags_reg & inten_reg);

  // ****************************************
  // start event input
  // ****************************************
  // three flops; a change counts once the second and third agree
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_s3_reg <= 1'b0;
      ev_lvl_reg <= 1'b0;
    end else begin
      ev_s1_reg <= start_event;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
      if (ev_s2_reg == ev_s3_reg) begin
        ev_lvl_reg <= ev_s3_reg;
      end
    end
  end

  // the invert bit in event control turns detection to the falling edge
  assign ev_edge = (ev_s2_reg == ev_s3_reg) & (ev_s3_reg != ev_lvl_reg)
                   & (ev_s3_reg != ev_ctrl_reg[EV_EDGE_INVERT]);

  // a detected event waits until the conversion path is free
  always_ff @(posedge clk) begin
    if (clr_all) begin
      start_pend_reg <= 1'b0;
    end else if (ev_edge & ev_ctrl_reg[EV_START_IN] & enable_active_reg) begin
      start_pend_reg <= 1'b1;
    end else if (start_take) begin
      start_pend_reg <= 1'b0;
    end
  end

  assign start_take = start_pend_reg & ~op_busy[OP_CONVERSION] & fifo_room;
  assign transfer = start_take & buf_full_reg;

  // ****************************************
  // two-stage value path
  // ****************************************
  // written values read back at once; the sync commit moves them on
  always_ff @(posedge clk) begin
    if (clr_all) begin
      conv_pend_reg <= VALUE_RST;
      buf_pend_reg <= VALUE_RST;
      buf_reg <= VALUE_RST;
      buf_full_reg <= 1'b0;
    end else begin
      if (op_start[OP_CONVERSION] & bus_req.be[0]) begin
        conv_pend_reg[7:0] <= wb0;
      end
      if (op_start[OP_CONVERSION] & bus_req.be[1]) begin
        conv_pend_reg[15:8] <= wb1;
      end
      if (transfer) begin
        conv_pend_reg <= buf_reg;
      end
      if (op_start[OP_BUFFERED] & bus_req.be[0]) begin
        buf_pend_reg[7:0] <= wb0;
      end
      if (op_start[OP_BUFFERED] & bus_req.be[1]) begin
        buf_pend_reg[15:8] <= wb1;
      end
      if (op_done[OP_BUFFERED]) begin
        buf_reg <= buf_pend_reg;
        buf_full_reg <= 1'b1;
      end else if (transfer) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  // empty event pulse when the buffered value moves on
  always_ff @(posedge clk) begin
    if (clr_all) begin
      empty_event <= 1'b0;
    end else begin
      empty_event <= transfer & ev_ctrl_reg[EV_EMPTY_OUT];
    end
  end

  // new conversion value from a bus commit or a start transfer
  assign push = op_done[OP_CONVERSION] | transfer;
  assign push_value = op_done[OP_CONVERSION] ? conv_pend_reg : buf_reg;
  assign push_code = ctrl_sec_reg[CB_JUSTIFY_HIGH] ? push_value[15:16-CODE_W]
                                                   : push_value[CODE_W-1:0];

  // two-entry buffer toward the core; a stall holds the sync in its last count
  assign fifo_room = fifo_cnt_reg != 2'h2;
  assign pop = code_valid & code_ready;
  assign code_valid = fifo_cnt_reg != 2'h0;
  assign code_data = fifo_mem[fifo_rp_reg];

  always_ff @(posedge clk) begin
    if (clr_all) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_wp_reg <= ~fifo_wp_reg;
      end
      if (pop) begin
        fifo_rp_reg <= ~fifo_rp_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else if (push) begin
      fifo_mem[fifo_wp_reg] <= push_code;
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  assign core_enable = enable_active_reg;
  assign analog.ref_sel = ctrl_sec_reg[CB_REF_LSB+1:CB_REF_LSB];
  assign analog.pin_drive = enable_active_reg & ctrl_sec_reg[CB_PIN_DRIVE];
  assign analog.adc_mux_drive = enable_active_reg & ctrl_sec_reg[CB_PIN_DRIVE];
  assign analog.comparator_route = enable_active_reg & ctrl_sec_reg[CB_INTERNAL_ROUTE];
  assign analog.pump_force_off = ctrl_sec_reg[CB_PUMP_DISABLE];
  assign analog.output_buffer_on = enable_active_reg & ctrl_sec_reg[CB_PIN_DRIVE]
                                   & (~standby | standby_run_reg);

  // ****************************************
  // assertions
  // ****************************************
  sequence s_conv_write;
    wr_conv & ~op_busy[OP_CONVERSION];
  endsequence

  sequence s_conv_done;
    op_done[OP_CONVERSION] & ~soft_clr;
  endsequence

  a_busy_sets_now: assert property (@(posedge clk) disable iff (rst)
    s_conv_write |=> op_busy[OP_CONVERSION]) else $error("busy not raised");

  a_enable_sync_ends: assert property (@(posedge clk) disable iff (rst)
    $rose(op_busy[OP_ENABLE]) |-> ##[1:A_SYNC_MAX] !op_busy[OP_ENABLE])
    else $error("enable sync never ends");

  a_drop_on_busy: assert property (@(posedge clk) disable iff (rst)
    (wr_conv & op_busy[OP_CONVERSION]) |=> bus_err && $stable(conv_pend_reg))
    else $error("colliding write not dropped");

  a_conv_starts: assert property (@(posedge clk) disable iff (rst)
    s_conv_done |=> code_valid && !op_busy[OP_CONVERSION])
    else $error("conversion not started");

  a_underrun_flag: assert property (@(posedge clk) disable iff (rst)
    (start_take & ~buf_full_reg & ~soft_clr) |=> flags_reg[IRQ_UNDERRUN])
    else $error("underrun lost");

  a_empty_event: assert property (@(posedge clk) disable iff (rst)
    (transfer & ev_ctrl_reg[EV_EMPTY_OUT] & ~soft_clr & ~op_done[OP_BUFFERED])
    |=> empty_event && !buf_full_reg
    && flags_reg[IRQ_EMPTY]) else $error("empty event missing");

  a_irq_combined: assert property (@(posedge clk) disable iff (rst)
    (flags_reg[IRQ_EMPTY] && inten_reg[IRQ_EMPTY]) |-> irq)
    else $error("interrupt not raised");

  a_protect_secondary: assert property (@(posedge clk) disable iff (rst)
    (wr & word0 & bus_req.be[1] & locked & ~soft_clr) |=> $stable(ctrl_sec_reg))
    else $error("protected write landed");

  a_reset_precedence: assert property (@(posedge clk) disable iff (rst)
    soft_reset_bit_wr |=> soft_reset_bit_reg && $stable(enable_reg) && $stable(standby_run_reg))
    else $error("soft reset write not exclusive");

  a_reset_completes: assert property (@(posedge clk) disable iff (rst)
    soft_clr |=> !soft_reset_bit_reg && !enable_active_reg && ctrl_sec_reg == 8'h00)
    else $error("soft reset incomplete");

  a_pump_control: assert property (@(posedge clk) disable iff (rst)
    $rose(ctrl_sec_reg[CB_PUMP_DISABLE]) |-> analog.pump_force_off)
    else $error("pump not forced off");

endmodule

// ### verification/dacr_core_model.sv
// behavioural converter core that takes codes through valid and ready
`timescale 1ns/1ps
module dacr_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic [9:0] code_data,
  input wire logic code_valid,
  output logic code_ready,
  output logic [9:0] last_code,
  output int taken
);
  // ready drops while the bench asks for a stall
  assign code_ready = !stall;
  // record each code that the core takes
  always @(posedge clk) begin
    if (rst) begin
      last_code <= 10'h000;
      taken <= 0;
    end else if (code_valid && code_ready) begin
      last_code <= code_data;
      taken <= taken + 1;
    end
  end
endmodule

// ### verification/dac_controller_regs_sync_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module dac_controller_regs_sync_bench;
  import dacr_pkg::*;
  logic clk = 0;
  logic rst = 1;
  dacr_bus_req_t bus_req = '0;
  logic bus_ready, bus_err, empty_event, irq, core_enable, code_valid, code_ready;
  logic start_event = 0;
  logic standby = 0;
  logic stall = 0;
  dacr_analog_t analog;
  logic [9:0] code_data, last_code;
  logic [31:0] bus_rdata, rv;
  logic [15:0] v;
  int taken;
  int tk;
  int bad_count = 0;
  int n_checks = 0;
  int n_empty = 0;
  // clock and instances
  always #4 clk = ~clk;
  dacr_ctrl #(.SYNC_CYC(8)) i_dacr_ctrl (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_err(bus_err),
    .start_event(start_event), .standby(standby), .empty_event(empty_event), .irq(irq),
    .core_enable(core_enable), .analog(analog), .code_data(code_data),
    .code_valid(code_valid), .code_ready(code_ready));
  dacr_core_model i_dacr_core_model (.clk(clk), .rst(rst), .stall(stall),
    .code_data(code_data), .code_valid(code_valid), .code_ready(code_ready),
    .last_code(last_code), .taken(taken));
  // count empty event pulses away from the active edge
  always @(negedge clk) if (empty_event === 1'b1) n_empty++;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access of n bytes at byte address a, answer checked for error
  task automatic acc(input logic w, input logic [4:0] a, input int n,
                     input logic [31:0] d, input logic e);
    logic [3:0] be;
    be = 4'((1 << n) - 1) << a[1:0];
    @(posedge clk);
    bus_req <= '{1'b1, w, a, be, d << (8 * a[1:0])};
    @(posedge clk);
    bus_req.sel <= 1'b0;
    #1;
    rv = 32'((64'(bus_rdata) >> (8 * a[1:0])) & ((64'h1 << (8 * n)) - 64'h1));
    chk(32'({bus_ready, bus_err}), 32'({1'b1, e}));
  endtask
  // wait for the core to take a code while stalling it at random
  task automatic code_chk(input logic [9:0] exp);
    int t0;
    t0 = taken;
    for (int i = 0; i < 80 && taken == t0; i++) begin
      @(posedge clk);
      stall <= ($urandom % 3) == 0;
    end
    @(posedge clk);
    stall <= 1'b0;
    chk(32'(last_code), 32'(exp));
  endtask
  task automatic pulse();
    @(posedge clk);
    start_event <= 1'b1;
    repeat (6) @(posedge clk);
    start_event <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(38));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      acc(1'b0, 5'(a), 4, 0, 1'b0);
      chk(rv, 0);
    end
    acc(1'b0, OFS_END, 4, 0, 1'b1);
    acc(1'b1, OFS_EVENT_CONTROL, 1, 32'h03, 1'b0);
    acc(1'b1, OFS_CONTROL_SECONDARY, 1, 32'h8F, 1'b0);
    acc(1'b1, OFS_IRQ_ENABLE_SET, 1, 32'h03, 1'b0);
    acc(1'b0, OFS_CONTROL_PRIMARY, 4, 0, 1'b0);
    chk(rv, 32'h0003_8F00);
    chk(32'(analog), 32'h42);
    acc(1'b1, OFS_CONTROL_PRIMARY, 1, 32'h02, 1'b0);
    acc(1'b0, OFS_SYNC_STATUS, 1, 0, 1'b0);
    chk(rv, 32'h80);
    acc(1'b1, OFS_CONTROL_PRIMARY, 1, 32'h00, 1'b1);
    acc(1'b0, OFS_CONTROL_PRIMARY, 1, 0, 1'b0);
    chk(rv, 32'h02);
    repeat (12) @(posedge clk);
    #1;
    chk(32'(core_enable), 1);
    chk(32'(analog), 32'h5F);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(analog.output_buffer_on), 0);
    standby <= 1'b0;
    acc(1'b1, OFS_CONTROL_SECONDARY, 1, 32'h00, 1'b0);
    acc(1'b0, OFS_CONTROL_SECONDARY, 1, 0, 1'b0);
    chk(rv, 32'h8F);
    // one code at a time, far below a quarter of the clock rate
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hFFC0 : 16'($urandom);
      acc(1'b1, OFS_CONVERSION_VALUE, 2, 32'(v), 1'b0);
      code_chk(v[15:6]);
    end
    acc(1'b1, OFS_BUFFERED_VALUE, 2, 32'h5540, 1'b0);
    repeat (12) @(posedge clk);
    pulse();
    code_chk(10'h155);
    chk(32'(n_empty), 1);
    acc(1'b0, OFS_IRQ_FLAGS, 1, 0, 1'b0);
    chk(rv & 32'h3, 32'h2);
    chk(32'(irq), 1);
    acc(1'b1, OFS_IRQ_FLAGS, 1, 32'h07, 1'b0);
    @(posedge clk);
    #1;
    chk(32'(irq), 0);
    pulse();
    acc(1'b0, OFS_IRQ_FLAGS, 1, 0, 1'b0);
    chk(rv & 32'h3, 32'h1);
    chk(32'(irq), 1);
    acc(1'b1, OFS_CONTROL_PRIMARY, 1, 32'h07, 1'b0);
    acc(1'b0, OFS_CONTROL_PRIMARY, 1, 0, 1'b0);
    chk(rv & 32'h1, 32'h1);
    repeat (14) @(posedge clk);
    acc(1'b0, OFS_CONTROL_PRIMARY, 4, 0, 1'b0);
    chk(rv, 0);
    chk(32'({core_enable, irq}), 0);
    // right-justified code, and a second write inside the sync time is dropped
    v = 16'($urandom);
    acc(1'b1, OFS_CONVERSION_VALUE, 2, 32'(v), 1'b0);
    acc(1'b1, OFS_CONVERSION_VALUE, 2, 32'(~v), 1'b1);
    code_chk(v[9:0]);
    // inverted start event: the rising edge is ignored, the falling edge moves the value
    v = 16'($urandom);
    acc(1'b1, OFS_BUFFERED_VALUE, 2, 32'(v), 1'b0);
    acc(1'b1, OFS_EVENT_CONTROL, 1, 32'h13, 1'b0);
    acc(1'b1, OFS_CONTROL_PRIMARY, 1, 32'h02, 1'b0);
    repeat (12) @(posedge clk);
    tk = taken;
    start_event <= 1'b1;
    repeat (12) @(posedge clk);
    chk(32'(taken - tk), 0);
    start_event <= 1'b0;
    repeat (12) @(posedge clk);
    chk(32'(taken - tk), 1);
    chk(32'(last_code), 32'(v[9:0]));
    chk(32'(n_empty), 2);
    conclude();
  end
endmodule
